// ==== logic/analog_power_control_regs.sv ====
// analog power control register bank on apb
// assumes apb master on pclk; analog flags asynchronous to pclk
// Operation
// R1: charger word bits 10:8 select charge current, eight steps.
// R2: charger word bits 6:4 select low-voltage level, reset code 100.
// R3: charger bit 3 reads charge-complete from the charger.
// R4: charger bit 2 reads charging-supply-ready.
// R5: charger bit 1 drives charge-path enable, reset 0.
// R6: charger bit 0 drives charger regulator enable, reset 0.
// R7: power word bit 7 reads over-temperature trip.
// R8: power word bit 6 reads low-voltage detector output.
// R9: power word bit 5 enables temperature sensor, reset 0.
// R10: power word bit 4 enables reference buffer, reset 0.
// R11: power word bits 3:1 select under-voltage threshold, reset 000.
// R12: power word bit 0 enables low-voltage detector, reset 0.
// R13: self-test bits 6:4 route one of six nodes; 110, 111 reserved.
// R14: self-test bit 0 enables analog test output, reset 0.
// R15: self-test bits 15:8 read spare analog signals, zero after reset.
// R16: writes to read-only, reserved bits or word 0x14 do nothing.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module analog_power_control_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [analog_power_pkg::addr_width-1:0] paddr,
    input wire logic [analog_power_pkg::data_width-1:0] pwdata,
    output logic [analog_power_pkg::data_width-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire analog_power_pkg::analog_status_s analog_in,
    output analog_power_pkg::charger_ctrl_s charger_out,
    output analog_power_pkg::power_mgmt_control_s pmu_out,
    output analog_power_pkg::selftest_ctrl_s selftest_out,
    output logic irq
);

    typedef struct packed {
        analog_power_pkg::charger_ctrl_s charger;
        analog_power_pkg::power_mgmt_control_s pmu;
        analog_power_pkg::selftest_ctrl_s selftest;
        logic [analog_power_pkg::event_count-1:0] irq_mask;
        logic [analog_power_pkg::data_width-1:0] rdata;
        logic slverr;
    } bank_state_s;

    bank_state_s state_reg;
    bank_state_s state_next;

    analog_power_pkg::analog_status_s status_sync;
    logic [analog_power_pkg::event_count-1:0] event_level;
    logic [analog_power_pkg::event_count-1:0] event_clear;
    logic [analog_power_pkg::event_count-1:0] event_bits;

    logic setup_phase;
    logic access_phase;
    logic write_access;

    analog_power_pkg::charger_word_s charger_wr;
    analog_power_pkg::pmu_word_s pmu_wr;
    analog_power_pkg::selftest_word_s selftest_wr;
    analog_power_pkg::irq_word_s irq_wr;

    // address match on the word; low two bits ignored
    function automatic logic reg_hit(
        input logic [analog_power_pkg::addr_width-1:0] addr,
        input logic [7:0] offset
    );
        reg_hit = (addr[analog_power_pkg::addr_width-1:2] == offset[7:2]);
    endfunction : reg_hit

    function automatic logic mapped(
        input logic [analog_power_pkg::addr_width-1:0] addr
    );
        mapped = reg_hit(addr, analog_power_pkg::charger_offset)
            | reg_hit(addr, analog_power_pkg::pmu_offset)
            | reg_hit(addr, analog_power_pkg::reserved_offset)
            | reg_hit(addr, analog_power_pkg::selftest_offset)
            | reg_hit(addr, analog_power_pkg::irq_status_offset)
            | reg_hit(addr, analog_power_pkg::irq_mask_offset);
    endfunction : mapped

    // flags from the analog side cross into pclk here
    input_sync #(
        .width($bits(analog_power_pkg::analog_status_s))
    ) u_status_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(analog_in),
        .sync_out(status_sync)
    );

    assign event_level = {
        status_sync.undervolt_flag,
        status_sync.overtemp_flag,
        status_sync.charge_supply_ok,
        status_sync.charge_done
    };

    event_status u_event_status (
        .pclk(pclk),
        .presetn(presetn),
        .level_in(event_level),
        .clear_in(event_clear),
        .mask_in(state_reg.irq_mask),
        .status_out(event_bits),
        .irq(irq)
    );

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign write_access = access_phase & pwrite;

    assign charger_wr = analog_power_pkg::charger_word_s'(pwdata);
    assign pmu_wr = analog_power_pkg::pmu_word_s'(pwdata);
    assign selftest_wr = analog_power_pkg::selftest_word_s'(pwdata);
    assign irq_wr = analog_power_pkg::irq_word_s'(pwdata);

    // write-one-to-clear on the status word
    always_comb begin
        event_clear = '0;
        if (write_access
            && reg_hit(paddr, analog_power_pkg::irq_status_offset)) begin
            event_clear = {
                irq_wr.undervolt,
                irq_wr.overtemp,
                irq_wr.supply_ok,
                irq_wr.charge_done
            };
        end
    end

    // read image of the addressed word
    function automatic logic [analog_power_pkg::data_width-1:0] read_word(
        input logic [analog_power_pkg::addr_width-1:0] addr,
        input bank_state_s st,
        input analog_power_pkg::analog_status_s flags,
        input logic [analog_power_pkg::event_count-1:0] events
    );
        analog_power_pkg::charger_word_s cw;
        analog_power_pkg::pmu_word_s pw;
        analog_power_pkg::selftest_word_s sw;
        analog_power_pkg::irq_word_s iw;
        cw = '0;
        pw = '0;
        sw = '0;
        iw = '0;
        cw.charge_current_level = st.charger.charge_current_level; // R1
        cw.charge_low_volt_level = st.charger.charge_low_volt_level; // R2
        cw.charge_done = flags.charge_done; // R3
        cw.charge_supply_ok = flags.charge_supply_ok; // R4
        cw.charge_path_on = st.charger.charge_path_on; // R5
        cw.charger_regulator_on = st.charger.charger_regulator_on; // R6
        pw.overtemp_flag = flags.overtemp_flag; // R7
        pw.undervolt_flag = flags.undervolt_flag; // R8
        pw.temp_sensor_on = st.pmu.temp_sensor_on; // R9
        pw.ref_buffer_on = st.pmu.ref_buffer_on; // R10
        pw.undervolt_threshold = st.pmu.undervolt_threshold; // R11
        pw.undervolt_detector_on = st.pmu.undervolt_detector_on; // R12
        sw.selftest_sel = st.selftest.selftest_sel; // R13
        sw.selftest_on = st.selftest.selftest_on; // R14
        sw.analog_spare_bits = flags.analog_spare_bits; // R15
        read_word = analog_power_pkg::word_zero;
        if (reg_hit(addr, analog_power_pkg::charger_offset)) begin
            read_word = cw;
        end else if (reg_hit(addr, analog_power_pkg::pmu_offset)) begin
            read_word = pw;
        end else if (reg_hit(addr, analog_power_pkg::selftest_offset)) begin
            read_word = sw;
        end else if (reg_hit(addr, analog_power_pkg::irq_status_offset)) begin
            iw.undervolt = events[3];
            iw.overtemp = events[2];
            iw.supply_ok = events[1];
            iw.charge_done = events[0];
            read_word = iw;
        end else if (reg_hit(addr, analog_power_pkg::irq_mask_offset)) begin
            iw.undervolt = st.irq_mask[3];
            iw.overtemp = st.irq_mask[2];
            iw.supply_ok = st.irq_mask[1];
            iw.charge_done = st.irq_mask[0];
            read_word = iw;
        end
    endfunction : read_word

    always_comb begin
        state_next = state_reg;

        // read data and error are caught in the setup cycle so that
        // prdata comes from a flop without adding a wait state
        if (setup_phase) begin
            state_next.slverr = ~mapped(paddr); // R16
            if (pwrite) begin
                state_next.rdata = analog_power_pkg::word_zero;
            end else begin
                state_next.rdata = read_word(paddr, state_reg, status_sync,
                    event_bits);
            end
        end

        // only writable fields are taken; everything else is dropped
        if (write_access) begin
            if (reg_hit(paddr, analog_power_pkg::charger_offset)) begin
                state_next.charger.charge_current_level =
                    charger_wr.charge_current_level; // R1
                state_next.charger.charge_low_volt_level =
                    charger_wr.charge_low_volt_level; // R2
                state_next.charger.charge_path_on =
                    charger_wr.charge_path_on; // R5
                state_next.charger.charger_regulator_on =
                    charger_wr.charger_regulator_on; // R6
            end
            if (reg_hit(paddr, analog_power_pkg::pmu_offset)) begin
                state_next.pmu.temp_sensor_on = pmu_wr.temp_sensor_on; // R9
                state_next.pmu.ref_buffer_on = pmu_wr.ref_buffer_on; // R10
                state_next.pmu.undervolt_threshold =
                    pmu_wr.undervolt_threshold; // R11
                state_next.pmu.undervolt_detector_on =
                    pmu_wr.undervolt_detector_on; // R12
            end
            if (reg_hit(paddr, analog_power_pkg::selftest_offset)) begin
                // reserved routes are refused; the mux keeps a legal node
                if (selftest_wr.selftest_sel
                    < analog_power_pkg::selftest_first_reserved) begin
                    state_next.selftest.selftest_sel =
                        selftest_wr.selftest_sel; // R13
                end
                state_next.selftest.selftest_on =
                    selftest_wr.selftest_on; // R14
            end
            if (reg_hit(paddr, analog_power_pkg::irq_mask_offset)) begin
                state_next.irq_mask = {
                    irq_wr.undervolt,
                    irq_wr.overtemp,
                    irq_wr.supply_ok,
                    irq_wr.charge_done
                };
            end
            // word 0x14 and unmapped words fall through untouched R16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.charger.charge_current_level <=
                analog_power_pkg::charge_current_reset;
            state_reg.charger.charge_low_volt_level <=
                analog_power_pkg::charge_low_volt_reset; // R2
            state_reg.charger.charge_path_on <= 1'b0;
            state_reg.charger.charger_regulator_on <= 1'b0;
            state_reg.pmu.temp_sensor_on <= 1'b0;
            state_reg.pmu.ref_buffer_on <= 1'b0;
            state_reg.pmu.undervolt_threshold <=
                analog_power_pkg::undervolt_threshold_reset; // R11
            state_reg.pmu.undervolt_detector_on <= 1'b0;
            state_reg.selftest.selftest_sel <=
                analog_power_pkg::selftest_sel_reset;
            state_reg.selftest.selftest_on <= 1'b0;
            state_reg.irq_mask <= analog_power_pkg::irq_mask_reset;
            state_reg.rdata <= analog_power_pkg::word_zero;
            state_reg.slverr <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // zero-wait slave: every access phase completes at once
    assign pready = access_phase;
    assign prdata = state_reg.rdata;
    assign pslverr = access_phase & state_reg.slverr;

    assign charger_out = state_reg.charger;
    assign pmu_out = state_reg.pmu;
    assign selftest_out = state_reg.selftest;

endmodule : analog_power_control_regs

// ==== logic/analog_power_pkg.sv ====
// analog power control: register offsets, word layouts, reset values
// assumes a 32-bit apb with byte addresses; analog macros outside
package analog_power_pkg;

    localparam int addr_width = 8;
    localparam int data_width = 32;
    localparam int event_count = 4;
    localparam int spare_width = 8;

    localparam logic [7:0] charger_offset = 8'h0c;
    localparam logic [7:0] pmu_offset = 8'h10;
    localparam logic [7:0] reserved_offset = 8'h14;
    localparam logic [7:0] selftest_offset = 8'h18;
    localparam logic [7:0] irq_status_offset = 8'h1c;
    localparam logic [7:0] irq_mask_offset = 8'h20;

    localparam logic [2:0] charge_current_reset = 3'h0;
    localparam logic [2:0] charge_low_volt_reset = 3'h4;
    localparam logic [2:0] undervolt_threshold_reset = 3'h0;
    localparam logic [2:0] selftest_sel_reset = 3'h0;
    localparam logic [2:0] selftest_first_reserved = 3'h6;
    localparam logic [3:0] irq_mask_reset = 4'h0;
    localparam logic [31:0] word_zero = 32'h0000_0000;

    // word images, msb first, so the struct fixes every field position
    typedef struct packed {
        logic [20:0] rsv_hi;
        logic [2:0] charge_current_level;
        logic rsv7;
        logic [2:0] charge_low_volt_level;
        logic charge_done;
        logic charge_supply_ok;
        logic charge_path_on;
        logic charger_regulator_on;
    } charger_word_s;

    typedef struct packed {
        logic [23:0] rsv_hi;
        logic overtemp_flag;
        logic undervolt_flag;
        logic temp_sensor_on;
        logic ref_buffer_on;
        logic [2:0] undervolt_threshold;
        logic undervolt_detector_on;
    } pmu_word_s;

    typedef struct packed {
        logic [15:0] rsv_hi;
        logic [7:0] analog_spare_bits;
        logic rsv7;
        logic [2:0] selftest_sel;
        logic [2:0] rsv_lo;
        logic selftest_on;
    } selftest_word_s;

    // event bits, shared by status and mask words
    typedef struct packed {
        logic [27:0] rsv_hi;
        logic undervolt;
        logic overtemp;
        logic supply_ok;
        logic charge_done;
    } irq_word_s;

    typedef struct packed {
        logic charge_done;
        logic charge_supply_ok;
        logic overtemp_flag;
        logic undervolt_flag;
        logic [7:0] analog_spare_bits;
    } analog_status_s;

    typedef struct packed {
        logic [2:0] charge_current_level;
        logic [2:0] charge_low_volt_level;
        logic charge_path_on;
        logic charger_regulator_on;
    } charger_ctrl_s;

    typedef struct packed {
        logic temp_sensor_on;
        logic ref_buffer_on;
        logic [2:0] undervolt_threshold;
        logic undervolt_detector_on;
    } power_mgmt_control_s;

    typedef struct packed {
        logic [2:0] selftest_sel;
        logic selftest_on;
    } selftest_ctrl_s;

endpackage : analog_power_pkg

// ==== logic/event_status.sv ====
// sticky event status with write-one-to-clear and masked interrupt
// assumes event levels already synchronised to pclk
`timescale 1ns/1ps
module event_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [analog_power_pkg::event_count-1:0] level_in,
    input wire logic [analog_power_pkg::event_count-1:0] clear_in,
    input wire logic [analog_power_pkg::event_count-1:0] mask_in,
    output logic [analog_power_pkg::event_count-1:0] status_out,
    output logic irq
);
    typedef struct packed {
        logic [analog_power_pkg::event_count-1:0] prev;
        logic [analog_power_pkg::event_count-1:0] status;
        logic irq;
    } event_state_s;

    event_state_s state_reg;
    event_state_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.prev = level_in;
        // rising edge sets; set wins over a same-cycle clear
        state_next.status = (state_reg.status & ~clear_in)
            | (level_in & ~state_reg.prev);
        state_next.irq = |(state_next.status & mask_in);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign status_out = state_reg.status;
    assign irq = state_reg.irq;
endmodule : event_status

// ==== logic/input_sync.sv ====
// three-stage synchroniser with agreement filter for analog flags
// assumes inputs are asynchronous levels from the analog macros
`timescale 1ns/1ps
module input_sync #(
    parameter int width = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    typedef struct packed {
        logic [width-1:0] s1;
        logic [width-1:0] s2;
        logic [width-1:0] s3;
        logic [width-1:0] q;
    } sync_state_s;

    sync_state_s state_reg;
    sync_state_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.s1 = async_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        // a bit moves only once stages two and three agree
        state_next.q = (~(state_reg.s2 ^ state_reg.s3) & state_reg.s3)
            | ((state_reg.s2 ^ state_reg.s3) & state_reg.q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.q;
endmodule : input_sync

// ==== test/analog_power_control_regs_chk.sv ====
// concurrent checks on the analog power register bank ports
// assumes one pclk domain, async active-low presetn
`timescale 1ns/1ps
module analog_power_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [analog_power_pkg::addr_width-1:0] paddr,
    input wire logic [analog_power_pkg::data_width-1:0] pwdata,
    input wire logic [analog_power_pkg::data_width-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire analog_power_pkg::analog_status_s analog_in,
    input wire analog_power_pkg::charger_ctrl_s charger_out,
    input wire analog_power_pkg::power_mgmt_control_s pmu_out,
    input wire analog_power_pkg::selftest_ctrl_s selftest_out,
    input wire logic irq
);
    localparam logic [5:0] chg = analog_power_pkg::charger_offset[7:2];
    localparam logic [5:0] pmu = analog_power_pkg::pmu_offset[7:2];
    localparam logic [5:0] rsv = analog_power_pkg::reserved_offset[7:2];
    localparam logic [5:0] sel = analog_power_pkg::selftest_offset[7:2];
    localparam logic [5:0] msk = analog_power_pkg::irq_mask_offset[7:2];
    logic [31:0] wd_q;
    logic [5:0] a;
    logic acc;
    logic wr;
    logic mapped;
    // last cycle's write data, so consequents need no $past on slices
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_q <= 32'h0000_0000;
        end else begin
            wd_q <= pwdata;
        end
    end
    assign a = paddr[7:2];
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign mapped = (a >= chg) && (a <= msk);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_zero_wait: assert property (pready == acc)
        else $error("pready not equal to psel and penable");
    a_err_access_only: assert property (pslverr |-> acc)
        else $error("pslverr outside access phase");
    a_err_unmapped: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_charger_write: assert property (wr && a == chg |=>
        charger_out == {wd_q[10:8], wd_q[6:4], wd_q[1:0]})
        else $error("charger outputs not loaded from write");
    a_pmu_write: assert property (wr && a == pmu |=>
        pmu_out == wd_q[5:0])
        else $error("power outputs not loaded from write");
    a_sel_taken: assert property (wr && a == sel && pwdata[6:4] < 3'h6
        |=> selftest_out == {wd_q[6:4], wd_q[0]})
        else $error("self-test select not taken");
    a_sel_refused: assert property (wr && a == sel && pwdata[6:4] > 3'h5
        |=> $stable(selftest_out.selftest_sel)
        && selftest_out.selftest_on == wd_q[0])
        else $error("reserved self-test code changed select");
    a_ctrl_hold: assert property (!wr || a == rsv || !mapped |=>
        $stable(charger_out) && $stable(pmu_out) && $stable(selftest_out))
        else $error("control outputs changed without a write");
    a_irq_masked: assert property (wr && a == msk && pwdata[3:0] == 4'h0
        |-> ##2 !irq)
        else $error("irq high with all events masked");
endmodule : analog_power_chk

bind analog_power_control_regs analog_power_chk chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .analog_in(analog_in),
    .charger_out(charger_out),
    .pmu_out(pmu_out),
    .selftest_out(selftest_out),
    .irq(irq)
);

// ==== test/analog_power_control_regs_tb.sv ====
// self-checking bench for the analog power register bank
// assumes zero-wait apb slave; flags lag analog_in by a few cycles
`timescale 1ns/1ps
module analog_power_control_regs_tb;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    analog_power_pkg::analog_status_s analog_in;
    analog_power_pkg::charger_ctrl_s charger_out;
    analog_power_pkg::power_mgmt_control_s pmu_out;
    analog_power_pkg::selftest_ctrl_s selftest_out;
    logic irq;
    int fail_count;
    int compares;
    logic [31:0] rd;
    logic err;
    logic [2:0] c;
    logic [2:0] s;

    analog_power_control_regs uut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .analog_in(analog_in),
        .charger_out(charger_out),
        .pmu_out(pmu_out),
        .selftest_out(selftest_out),
        .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (exp !== got) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 16) begin
                fail_count++;
                tally_and_finish();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(what, exp, rd);
    endtask : rdchk

    // irq is registered behind the mask flop: two edges to follow a write
    task automatic irq_is(input logic exp);
        repeat (2) @(negedge pclk);
        check("irq", {31'h0, exp}, {31'h0, irq});
    endtask : irq_is

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        analog_in = 12'h000;
        fail_count = 0;
        compares = 0;
        s = 3'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("charger", 8'h0c, 32'h0000_0040);
        rdchk("power", 8'h10, 32'h0000_0000);
        rdchk("selftest", 8'h18, 32'h0000_0000);
        rdchk("irq mask", 8'h20, 32'h0000_0000);
        check("charger pins", 32'h0000_0010, {24'h0, charger_out});
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(8'h0c, {21'h1f_ffff, c, 1'b1, ~c, 2'b11, c[1:0]});
            rdchk("charger", 8'h0c, {21'h0, c, 1'b0, ~c, 4'h0 | c[1:0]});
            check("chg pins", {24'h0, c, ~c, c[1:0]}, {24'h0, charger_out});
            wr(8'h10, {24'hff_ffff, 2'b11, c[0], ~c[0], c, c[2]});
            rdchk("power", 8'h10, {26'h0, c[0], ~c[0], c, c[2]});
            check("pmu pins", {26'h0, c[0], ~c[0], c, c[2]}, {26'h0, pmu_out});
            wr(8'h18, {24'hff_ffff, 1'b1, c, 3'b111, c[0]});
            if (c < 3'h6) begin
                s = c;
            end
            rdchk("selftest", 8'h18, {25'h0, s, 3'h0, c[0]});
            check("st pins", {28'h0, s, c[0]}, {28'h0, selftest_out});
        end
        // reserved word answers without error but keeps nothing
        wr(8'h14, 32'hffff_ffff);
        check("pslverr", 32'h0, {31'h0, err});
        rdchk("reserved", 8'h14, 32'h0000_0000);
        rdchk("charger", 8'h0c, 32'h0000_0703);
        xfer(1'b0, 8'h24, 32'h0000_0000);
        check("unmapped data", 32'h0, rd);
        check("unmapped err", 32'h1, {31'h0, err});
        wr(8'h28, 32'hffff_ffff);
        check("unmapped err", 32'h1, {31'h0, err});
        analog_in <= 12'hfa5;
        repeat (8) @(posedge pclk);
        rdchk("charger", 8'h0c, 32'h0000_070f);
        rdchk("power", 8'h10, 32'h0000_00ef);
        rdchk("selftest", 8'h18, 32'h0000_a551);
        rdchk("irq status", 8'h1c, 32'h0000_000f);
        irq_is(1'b0);
        wr(8'h20, 32'h0000_0001);
        irq_is(1'b1);
        wr(8'h1c, 32'h0000_0001);
        irq_is(1'b0);
        rdchk("irq status", 8'h1c, 32'h0000_000e);
        wr(8'h20, 32'hffff_ffff);
        irq_is(1'b1);
        rdchk("irq mask", 8'h20, 32'h0000_000f);
        wr(8'h1c, 32'hffff_ffff);
        irq_is(1'b0);
        @(posedge pclk);
        analog_in <= 12'h000;
        repeat (8) @(posedge pclk);
        rdchk("irq status", 8'h1c, 32'h0000_0000);
        analog_in <= 12'h100;
        repeat (8) @(posedge pclk);
        rdchk("irq status", 8'h1c, 32'h0000_0008);
        irq_is(1'b1);
        wr(8'h20, 32'h0000_0000);
        irq_is(1'b0);
        tally_and_finish();
    end
endmodule : analog_power_control_regs_tb
